// file: rtl/adc_pga_control_status_regs.sv
// Overview of operation
// - clock ratio field 6:4 picks divide 1,1.5,2,3,4; codes above 4 reserved
// - monitor enable bit 6 low floats both monitor pins, high drives them
// - level code is two's complement, LSB equals half a dB
// - channel B level at 07h, channel A at 08h, bits 7:6 reserved
// - transition mode: immediate, zero cross, ramp, ramp with zero cross (default)
// - ramp moves in eighth dB steps, 1 dB per 8 frame clocks
// - zero cross applies change at crossing or after 512 to 1024 samples
// - ramp plus zero cross: each eighth step waits crossing or timeout
// - crossing detect and timeout run separately for each channel
// - mute transitions follow the same ramp and crossing sequencing
// - source select: 000 microphone with boost, 001..110 line pairs, 111 reserved
// - polarity 1 gives active-high push-pull, 0 active-low open drain
// - flags are sticky and clear when the flag register is read
// - a masked flag always reads zero
// - flags reset to 00h: clock fault 3, over range 1, under range 0
// - mask bit 1 lets its condition set the flag, 0 blocks it
// - mode code per flag: high from 0Fh, low from 10h; 00 rise,01 fall,10 level
// - rise sets at start, fall at end, level while present
// - hold bit buffers mute and level writes, released together on clear
//
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
module adc_pga_control_status_regs (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [6:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   // converter side
   input wire logic frame_clock_i,
   input wire logic zero_cross_a_i,
   input wire logic zero_cross_b_i,
   input wire logic [7:0] event_cond_i,
   input wire logic mute_i,
   input wire logic [7:0] amp_out_left_i,
   input wire logic [7:0] amp_out_right_i,
   // controls to analog and clocking
   output logic [2:0] clock_ratio_o,
   output logic [2:0] input_source_o,
   output logic mic_boost_en_o,
   output logic [7:0] level_a_o,
   output logic [7:0] level_b_o,
   // monitor pins
   output logic [7:0] monitor_out_left_o,
   output logic [7:0] monitor_out_right_o,
   output logic monitor_oe_n_o,
   // interrupt pin
   output logic irq_o,
   output logic irq_oe_n_o
);
   logic [2:0] clock_ratio;
   logic monitor_en;
   logic [5:0] code_a, code_b, code_a_live, code_b_live;
   logic [1:0] transition;
   logic [2:0] source;
   logic polarity;
   logic [7:0] flags, mask, mode_hi, mode_lo;
   logic hold, mute_reg, mute_live;
   logic [2:0] frame_sync;
   logic frame_prev;
   logic [7:0] cond_q;
   logic [7:0] hit;
   logic req, wr, rd, flag_read;
   logic [4:0] idx;
   logic mapped;
   logic [7:0] rdata;
   logic frame_rise;
   level_step_if step_a ();
   level_step_if step_b ();

   assign req = cyc_i && stb_i && !ack_o && !err_o;
   assign idx = adr_i[6:2];
   assign wr = req && we_i && mapped && sel_i[0];
   assign rd = req && !we_i && mapped;
   assign flag_read = rd && idx == level_regs_pkg::EVENT_FLAGS_IDX;
   always_comb begin
      mapped = 1'b1;
      rdata = 8'h00;
      unique case (idx)
         level_regs_pkg::CLOCK_RATIO_IDX: rdata = {1'b0, clock_ratio, 4'h0};
         level_regs_pkg::MONITOR_CTRL_IDX: rdata = {1'b0, monitor_en, 6'h00};
         level_regs_pkg::CHAN_B_LEVEL_IDX: rdata = {2'h0, code_b};
         level_regs_pkg::CHAN_A_LEVEL_IDX: rdata = {2'h0, code_a};
         level_regs_pkg::INPUT_SEL_IDX: rdata = {3'h0, transition, source};
         level_regs_pkg::IRQ_POLARITY_IDX: rdata = {7'h00, polarity};
         level_regs_pkg::EVENT_FLAGS_IDX: rdata = flags & mask;
         level_regs_pkg::EVENT_MASK_IDX: rdata = mask;
         level_regs_pkg::MODE_HIGH_IDX: rdata = mode_hi;
         level_regs_pkg::MODE_LOW_IDX: rdata = mode_lo;
         level_regs_pkg::HOLD_CTRL_IDX: rdata = {hold, 4'h0, mute_reg, 2'h0};
         default: mapped = 1'b0;
      endcase
   end

   // bus answer one cycle after the request; unmapped gets err
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req && mapped;
         err_o <= req && !mapped;
         if (rd) dat_o <= {24'h000000, rdata};
      end
   end

   // plain configuration registers; reserved codes stored as written
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_ratio <= level_regs_pkg::CLOCK_RATIO_RST;
         monitor_en <= level_regs_pkg::MONITOR_EN_RST;
         transition <= level_regs_pkg::TRANSITION_RST;
         source <= level_regs_pkg::SOURCE_RST;
         polarity <= level_regs_pkg::POLARITY_RST;
         mask <= 8'h00;
         mode_hi <= 8'h00;
         mode_lo <= 8'h00;
         hold <= 1'b0;
         mute_reg <= 1'b0;
      end else if (wr) begin
         unique case (idx)
            level_regs_pkg::CLOCK_RATIO_IDX: clock_ratio <= dat_i[level_regs_pkg::CLOCK_RATIO_LSB +: 3];
            level_regs_pkg::MONITOR_CTRL_IDX: monitor_en <= dat_i[level_regs_pkg::MONITOR_EN_BIT];
            level_regs_pkg::INPUT_SEL_IDX: begin
               transition <= dat_i[level_regs_pkg::ZERO_CROSS_BIT +: 2];
               source <= dat_i[2:0];
            end
            level_regs_pkg::IRQ_POLARITY_IDX: polarity <= dat_i[0];
            level_regs_pkg::EVENT_MASK_IDX: mask <= dat_i[7:0] & level_regs_pkg::EVENT_VALID_BITS;
            level_regs_pkg::MODE_HIGH_IDX: mode_hi <= dat_i[7:0] & level_regs_pkg::EVENT_VALID_BITS;
            level_regs_pkg::MODE_LOW_IDX: mode_lo <= dat_i[7:0] & level_regs_pkg::EVENT_VALID_BITS;
            level_regs_pkg::HOLD_CTRL_IDX: begin
               hold <= dat_i[level_regs_pkg::HOLD_BIT];
               mute_reg <= dat_i[level_regs_pkg::MUTE_BIT];
            end
            default: ;
         endcase
      end
   end

   // level codes as written
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         code_a <= 6'h00;
         code_b <= 6'h00;
      end else if (wr) begin
         if (idx == level_regs_pkg::CHAN_A_LEVEL_IDX) code_a <= dat_i[5:0];
         if (idx == level_regs_pkg::CHAN_B_LEVEL_IDX) code_b <= dat_i[5:0];
      end
   end

   // live copies follow only while hold is clear, so held writes land together
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         code_a_live <= 6'h00;
         code_b_live <= 6'h00;
         mute_live <= 1'b0;
      end else if (!hold) begin
         code_a_live <= code_a;
         code_b_live <= code_b;
         mute_live <= mute_reg || mute_i;
      end
   end

   // frame clock is a pin: three stages, edge when stages two and three agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_sync <= 3'h0;
         frame_prev <= 1'b0;
      end else begin
         frame_sync <= {frame_sync[1:0], frame_clock_i};
         if (frame_sync[2] == frame_sync[1]) frame_prev <= frame_sync[2];
      end
   end
   assign frame_rise = frame_sync[2] && frame_sync[1] && !frame_prev;

   // mute drives the target to the floor, sequenced like any change
   assign step_a.target = mute_live ? level_regs_pkg::MUTE_LEVEL : {code_a_live, 2'h0};
   assign step_b.target = mute_live ? level_regs_pkg::MUTE_LEVEL : {code_b_live, 2'h0};
   assign step_a.ramp_en = transition[1];
   assign step_b.ramp_en = transition[1];
   assign step_a.zc_en = transition[0];
   assign step_b.zc_en = transition[0];
   assign step_a.frame_tick = frame_rise;
   assign step_b.frame_tick = frame_rise;

   level_sequencer #(.TIMEOUT(level_regs_pkg::ZC_TIMEOUT_SAMPLES)) seq_a (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .zero_cross_i(zero_cross_a_i),
      .bus(step_a)
   );
   level_sequencer #(.TIMEOUT(level_regs_pkg::ZC_TIMEOUT_SAMPLES)) seq_b (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .zero_cross_i(zero_cross_b_i),
      .bus(step_b)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_a_o <= 8'h00;
         level_b_o <= 8'h00;
         clock_ratio_o <= level_regs_pkg::CLOCK_RATIO_RST;
         input_source_o <= level_regs_pkg::SOURCE_RST;
         mic_boost_en_o <= 1'b0;
      end else begin
         level_a_o <= step_a.level;
         level_b_o <= step_b.level;
         clock_ratio_o <= clock_ratio;
         input_source_o <= source;
         mic_boost_en_o <= source == 3'h0;
      end
   end

   // monitor pins float while disabled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         monitor_out_left_o <= 8'h00;
         monitor_out_right_o <= 8'h00;
         monitor_oe_n_o <= 1'b1;
      end else begin
         monitor_out_left_o <= amp_out_left_i;
         monitor_out_right_o <= amp_out_right_i;
         monitor_oe_n_o <= !monitor_en;
      end
   end

   // condition inputs come from same-clock logic, no synchroniser
   always_ff @(posedge clk_i) begin
      if (rst_i) cond_q <= 8'h00;
      else cond_q <= event_cond_i;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         unique case ({mode_hi[i], mode_lo[i]})
            2'b00: hit[i] = event_cond_i[i] && !cond_q[i];
            2'b01: hit[i] = !event_cond_i[i] && cond_q[i];
            2'b10: hit[i] = event_cond_i[i];
            default: hit[i] = 1'b0;
         endcase
      end
   end

   // set wins over the read clear
   always_ff @(posedge clk_i) begin
      if (rst_i) flags <= level_regs_pkg::FLAGS_RST;
      else flags <= ((flag_read ? 8'h00 : flags) | (hit & mask)) & level_regs_pkg::EVENT_VALID_BITS;
   end

   // open drain drives only low; push-pull drives both levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         irq_oe_n_o <= 1'b1;
      end else begin
         irq_o <= polarity ? |(flags & mask) : 1'b0;
         irq_oe_n_o <= polarity ? 1'b0 : !(|(flags & mask));
      end
   end
endmodule // adc_pga_control_status_regs

// file: rtl/level_regs_pkg.sv
package level_regs_pkg;
   // register offsets (byte address = 4 * index)
   localparam logic [4:0] CLOCK_RATIO_IDX = 5'h05;
   localparam logic [4:0] MONITOR_CTRL_IDX = 5'h06;
   localparam logic [4:0] CHAN_B_LEVEL_IDX = 5'h07;
   localparam logic [4:0] CHAN_A_LEVEL_IDX = 5'h08;
   localparam logic [4:0] INPUT_SEL_IDX = 5'h09;
   localparam logic [4:0] IRQ_POLARITY_IDX = 5'h0C;
   localparam logic [4:0] EVENT_FLAGS_IDX = 5'h0D;
   localparam logic [4:0] EVENT_MASK_IDX = 5'h0E;
   localparam logic [4:0] MODE_HIGH_IDX = 5'h0F;
   localparam logic [4:0] MODE_LOW_IDX = 5'h10;
   localparam logic [4:0] HOLD_CTRL_IDX = 5'h11;
   // field positions
   localparam int CLOCK_RATIO_LSB = 4;
   localparam int MONITOR_EN_BIT = 6;
   localparam int RAMP_EN_BIT = 4;
   localparam int ZERO_CROSS_BIT = 3;
   localparam int HOLD_BIT = 7;
   localparam int MUTE_BIT = 2;
   // event flag bits: clock fault 3, over range 1, under range 0
   localparam logic [7:0] EVENT_VALID_BITS = 8'h0B;
   // reset values
   localparam logic [2:0] CLOCK_RATIO_RST = 3'h0;
   localparam logic MONITOR_EN_RST = 1'b1;
   localparam logic [1:0] TRANSITION_RST = 2'h3;
   localparam logic [2:0] SOURCE_RST = 3'h1;
   localparam logic POLARITY_RST = 1'b0;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   // level in 1/8 dB units; code LSB is 0.5 dB = 4 eighths
   localparam int LEVEL_W = 8;
   localparam logic [7:0] MUTE_LEVEL = 8'hA0;
   localparam int RAMP_FRAMES_PER_STEP = 1;
   localparam int ZC_TIMEOUT_SAMPLES = 512;
   localparam int ZC_TIMEOUT_MAX = 1024;
endpackage

// file: rtl/level_sequencer.sv
`timescale 1ns/100ps
module level_sequencer #(
   parameter int TIMEOUT = level_regs_pkg::ZC_TIMEOUT_SAMPLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // channel signal zero crossing, one-cycle pulse
   input wire logic zero_cross_i,
   // control
   level_step_if.chan bus
);
   if (TIMEOUT < 1 || TIMEOUT > level_regs_pkg::ZC_TIMEOUT_MAX) begin : g_bad_timeout
      $error("bad timeout");
   end
   logic [10:0] wait_cnt;
   logic [7:0] lvl;
   logic signed [8:0] diff;
   logic timed_out;
   logic apply;
   logic [7:0] next_level;
   assign bus.level = lvl;
   assign diff = $signed({lvl[7], lvl}) - $signed({bus.target[7], bus.target});
   assign timed_out = wait_cnt >= 11'(TIMEOUT);
   // with zero cross on, crossing or timeout gates each change, per channel
   // with crossing on, crossings pace the ramp; a crossing rarely meets a frame tick
   assign apply = diff != 0 && (bus.zc_en ? (zero_cross_i || timed_out) : (!bus.ramp_en || bus.frame_tick));
   always_comb begin
      next_level = lvl;
      if (bus.ramp_en) begin
         // one eighth dB per step; 8 steps per 8 frames is 1 dB
         if (diff < 0) next_level = lvl + 8'h01;
         else if (diff > 0) next_level = lvl - 8'h01;
      end else begin
         next_level = bus.target;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wait_cnt <= 11'h000;
      end else if (diff == 0 || apply) begin
         wait_cnt <= 11'h000;
      end else if (bus.zc_en && bus.frame_tick && !timed_out) begin
         wait_cnt <= wait_cnt + 11'h001;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl <= 8'h00;
      end else if (apply) begin
         lvl <= next_level;
      end
   end
endmodule // level_sequencer

// file: rtl/level_step_if.sv
`timescale 1ns/100ps
interface level_step_if;
   logic [7:0] target;
   logic ramp_en;
   logic zc_en;
   logic frame_tick;
   logic [7:0] level;
   modport ctrl (output target, output ramp_en, output zc_en, output frame_tick, input level);
   modport chan (input target, input ramp_en, input zc_en, input frame_tick, output level);
endinterface

// file: sim/adc_pga_control_status_regs_tb.sv
`timescale 1ns/100ps
module adc_pga_control_status_regs_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack, err, boost, moe_n, irq, irq_oe_n;
   logic frame = 1'b0, zca = 1'b0, zcb = 1'b0, mute = 1'b0;
   logic [6:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   logic [7:0] cond = 8'h00, amp_l = 8'h5A, amp_r = 8'hC3, mon_l, mon_r, lvl_a, lvl_b;
   logic [2:0] ratio, src;
   logic [33:0] note;
   logic [5:0] code;
   int seed = 99080;
   int n_mismatch = 0;
   int n_tests = 0;
   wb_host i_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat),
      .ack_i(ack), .err_i(err));
   adc_pga_control_status_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err), .frame_clock_i(frame),
      .zero_cross_a_i(zca), .zero_cross_b_i(zcb), .event_cond_i(cond), .mute_i(mute), .amp_out_left_i(amp_l),
      .amp_out_right_i(amp_r), .clock_ratio_o(ratio), .input_source_o(src), .mic_boost_en_o(boost),
      .level_a_o(lvl_a), .level_b_o(lvl_b), .monitor_out_left_o(mon_l), .monitor_out_right_o(mon_r),
      .monitor_oe_n_o(moe_n), .irq_o(irq), .irq_oe_n_o(irq_oe_n));
   always #2 clk_i = ~clk_i;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wr(input logic [4:0] i, input logic [7:0] d);
      i_host.xfer(1'b1, i, d, 34'h0);
   endtask
   task automatic rd(input logic [4:0] i, input logic [31:0] e);
      i_host.xfer(1'b0, i, 8'h00, {2'b10, e});
   endtask
   // frame clock stands low between ticks, 16 system cycles per frame
   task automatic tick(input int n);
      repeat (n) begin
         frame <= 1'b1;
         idle(8);
         frame <= 1'b0;
         idle(8);
      end
   endtask
   task automatic zpulse(input logic b);
      if (b) zcb <= 1'b1;
      else zca <= 1'b1;
      @(posedge clk_i);
      {zca, zcb} <= 2'h0;
      idle(4);
   endtask
   always @(posedge clk_i) begin
      if (ack || err) begin
         note = i_host.notes.pop_front();
         check("bus error", 32'(err), 32'(note[32]));
         if (note[33]) check("read data", rdat, note[31:0]);
      end
   end
   initial begin
      idle(40000);
      n_mismatch++;
      close_out();
   end
   initial begin
      idle(3);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(5'h06, 32'h40);
      rd(5'h09, 32'h19);
      for (int i = 12; i <= 16; i++) rd(5'(i), 32'h0);
      for (int k = 0; k <= 4; k++) begin
         wr(5'h05, 8'(k << 4));
         rd(5'h05, 32'(k << 4));
         check("ratio", 32'(ratio), 32'(k));
      end
      for (int k = 0; k <= 6; k++) begin
         wr(5'h09, 8'(k));
         check("source", 32'({boost, src}), 32'({k == 0, 3'(k)}));
      end
      wr(5'h06, 8'h00);
      idle(2);
      check("monitor float", 32'(moe_n), 32'h1);
      wr(5'h06, 8'h40);
      amp_l <= 8'($random(seed));
      amp_r <= 8'($random(seed));
      idle(3);
      check("monitor drive", {moe_n, 7'h0, mon_l, mon_r}, {8'h0, amp_l, amp_r});
      for (int ch = 1; ch >= 0; ch--) begin
         code = 6'($random(seed) % 25);
         wr(5'(7 + ch), {2'h0, code});
         rd(5'(7 + ch), 32'(code));
         idle(4);
         check("level", 32'(ch ? lvl_a : lvl_b), 32'({code, 2'h0}));
      end
      wr(5'h11, 8'h80);
      wr(5'h08, 8'h08);
      wr(5'h07, 8'h08);
      idle(6);
      check("held level", 32'(lvl_b), 32'({code, 2'h0}));
      wr(5'h11, 8'h00);
      idle(6);
      check("released levels", 32'({lvl_a, lvl_b}), 32'h2020);
      mute <= 1'b1;
      idle(6);
      check("mute level", 32'(lvl_a), 32'(level_regs_pkg::MUTE_LEVEL));
      mute <= 1'b0;
      idle(6);
      wr(5'h11, 8'h04);
      idle(4);
      check("mute reg level", 32'(lvl_b), 32'(level_regs_pkg::MUTE_LEVEL));
      wr(5'h11, 8'h00);
      idle(6);
      wr(5'h09, 8'h11);
      wr(5'h08, 8'h02);
      tick(4);
      check("ramp step", 32'(lvl_a), 32'h1C);
      tick(30);
      check("ramp end", 32'(lvl_a), 32'h08);
      wr(5'h09, 8'h09);
      wr(5'h08, 8'h00);
      wr(5'h07, 8'h04);
      idle(4);
      check("zc wait", 32'({lvl_a, lvl_b}), 32'h0820);
      zpulse(1'b1);
      check("zc b only", 32'({lvl_a, lvl_b}), 32'h0810);
      zpulse(1'b0);
      check("zc a", 32'(lvl_a), 32'h00);
      wr(5'h08, 8'h01);
      tick(500);
      check("zc early", 32'(lvl_a), 32'h00);
      tick(530);
      check("zc timeout", 32'(lvl_a), 32'h04);
      wr(5'h09, 8'h19);
      wr(5'h08, 8'h03);
      zpulse(1'b0);
      check("ramp zc step", 32'(lvl_a), 32'h05);
      i_host.xfer(1'b0, 5'h0A, 8'h00, {2'b01, 32'h0});
      wr(5'h0E, 8'h02);
      wr(5'h0C, 8'h00);
      cond <= 8'h03;
      idle(4);
      check("irq open drain", 32'({irq_oe_n, irq}), 32'h0);
      rd(5'h0D, 32'h02);
      rd(5'h0D, 32'h00);
      idle(2);
      check("irq released", 32'(irq_oe_n), 32'h1);
      wr(5'h0E, 8'h0B);
      wr(5'h10, 8'h02);
      cond <= 8'h00;
      idle(4);
      rd(5'h0D, 32'h02);
      wr(5'h0F, 8'h08);
      wr(5'h0C, 8'h01);
      cond <= 8'h08;
      idle(4);
      check("irq push pull", 32'({irq_oe_n, irq}), 32'h1);
      rd(5'h0D, 32'h08);
      rd(5'h0D, 32'h08);
      cond <= 8'h00;
      idle(2);
      rd(5'h0D, 32'h08);
      rd(5'h0D, 32'h00);
      idle(2);
      check("irq idle", 32'({irq_oe_n, irq}), 32'h0);
      // reserved mode code on under range must never set its flag
      wr(5'h0F, 8'h09);
      wr(5'h10, 8'h03);
      cond <= 8'h01;
      idle(4);
      rd(5'h0D, 32'h00);
      close_out();
   end
endmodule // adc_pga_control_status_regs_tb

// file: sim/regs_chk.sv
`timescale 1ns/100ps
module regs_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [6:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic err_o,
   // pins
   input wire logic [7:0] amp_out_left_i,
   input wire logic [7:0] monitor_out_left_o,
   input wire logic monitor_oe_n_o,
   input wire logic [2:0] clock_ratio_o,
   input wire logic [2:0] input_source_o,
   input wire logic mic_boost_en_o,
   input wire logic [7:0] level_a_o,
   input wire logic [7:0] level_b_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [4:0] ix;
   logic mapped;
   assign ix = adr_i[6:2];
   assign mapped = (ix >= 5'h05 && ix <= 5'h09) || (ix >= 5'h0C && ix <= 5'h11);
   sequence s_take;
      cyc_i && stb_i && !ack_o && !err_o;
   endsequence
   sequence s_read(logic [4:0] at);
      s_take ##0 (ix == at && !we_i);
   endsequence
   a_mapped_ack: assert property (s_take ##0 mapped |=> ack_o && !err_o)
      else $error("mapped access not acknowledged");
   a_unmapped_err: assert property (s_take ##0 !mapped |=> err_o && !ack_o)
      else $error("unmapped access not refused");
   a_flag_reserved: assert property (s_read(5'h0D) |=> ack_o ##0 dat_o == (dat_o & 32'(level_regs_pkg::EVENT_VALID_BITS)))
      else $error("reserved flag bit read as one");
   a_level_read: assert property (s_read(5'h07) or s_read(5'h08) |=> dat_o[31:6] == 26'h0)
      else $error("level register reserved bits set");
   a_boost_source: assert property (mic_boost_en_o == (input_source_o == 3'h0))
      else $error("boost does not match source");
   a_ratio_legal: assert property (clock_ratio_o <= 3'h4)
      else $error("reserved clock ratio driven");
   a_level_range: assert property ($signed(level_a_o) >= -96 && $signed(level_a_o) <= 96 && $signed(level_b_o) >= -96 && $signed(level_b_o) <= 96)
      else $error("level outside range");
   a_monitor_follow: assert property (!monitor_oe_n_o && $past(!monitor_oe_n_o) |-> monitor_out_left_o == $past(amp_out_left_i))
      else $error("monitor pin not following amplifier");
endmodule // regs_chk
bind adc_pga_control_status_regs regs_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .amp_out_left_i(amp_out_left_i),
   .monitor_out_left_o(monitor_out_left_o), .monitor_oe_n_o(monitor_oe_n_o), .clock_ratio_o(clock_ratio_o),
   .input_source_o(input_source_o), .mic_boost_en_o(mic_boost_en_o), .level_a_o(level_a_o), .level_b_o(level_b_o));

// file: sim/wb_host.sv
`timescale 1ns/100ps
module wb_host (
   // clock
   input wire logic clk_i,
   // bus
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [6:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o,
   input wire logic ack_i,
   input wire logic err_i
);
   // note: check data, expect error, data
   logic [33:0] notes[$];
   initial begin
      {cyc_o, stb_o, we_o, sel_o} = 7'h00;
      adr_o = 7'h00;
      dat_o = 32'h0;
   end
   task automatic xfer(input logic w, input logic [4:0] i, input logic [7:0] d, input logic [33:0] note);
      notes.push_back(note);
      {cyc_o, stb_o, we_o, sel_o} <= {3'b111 & {2'b11, w}, 4'hF};
      adr_o <= {i, 2'h0};
      dat_o <= {24'h0, d};
      do @(posedge clk_i); while (!(ack_i || err_i));
      {cyc_o, stb_o} <= 2'h0;
      // released lines carry junk so a stale value is never trusted
      adr_o <= ~adr_o;
      dat_o <= ~dat_o;
      @(posedge clk_i);
   endtask
endmodule // wb_host
